// File: rtl/ps_fault_mem.sv
// Small record memory for the last faults of one stage.
// Assumes one clock; read data come from a register one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module ps_fault_mem #(
    parameter int W = 84,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    // Read side
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data_q
);
    logic [W-1:0] mem_q [DEPTH];

    if (DEPTH != (1 << AW)) begin : g_chk
        $error("ps_fault_mem: DEPTH must equal 2**AW");
    end

    // Contents are volatile and carry no reset, like the records they hold.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= mem_q[rd_addr];
        end
    end
endmodule : ps_fault_mem
`default_nettype wire

// File: rtl/ps_pkg.sv
// Constants, types and timing counts shared by the protection stage core.
// Assumes a single 20 MHz system clock; all counts are derived from it.
package ps_pkg;
    localparam int PS_GROUPS = 4;
    localparam int PS_GRP_W = 2;
    localparam int PS_MEAS_W = 16;
    localparam int PS_TIME_W = 34;
    localparam int PS_ACC_W = 48;
    localparam int PS_TS_W = 32;
    localparam int PS_REC_DEPTH = 8;
    localparam int PS_REC_AW = 3;
    localparam int PS_REC_W = PS_TS_W + PS_MEAS_W + PS_TIME_W + PS_GRP_W;
    localparam longint PS_CLK_HZ = 20_000_000;
    // Forced start or trip lasts this long.
    localparam longint PS_FORCE_MS = 500;
    localparam logic [PS_TIME_W-1:0] PS_FORCE_CYC =
        PS_TIME_W'(PS_CLK_HZ / 1000 * PS_FORCE_MS);
    // Test forcing drops this long after the last push-button activity.
    localparam longint PS_TEST_TIMEOUT_S = 300;
    localparam logic [PS_TIME_W-1:0] PS_TEST_TIMEOUT_CYC =
        PS_TIME_W'(PS_CLK_HZ * PS_TEST_TIMEOUT_S);
    // Longest dependent-time operate delay.
    localparam longint PS_DEP_MAX_S = 600;
    localparam logic [PS_TIME_W-1:0] PS_DEP_MAX_CYC =
        PS_TIME_W'(PS_CLK_HZ * PS_DEP_MAX_S);
    // Squelch at 5/1000 of nominal current.
    localparam int PS_SQ_NUM = 5;
    localparam int PS_SQ_DEN = 1000;
    localparam logic [PS_GRP_W-1:0] PS_GROUP_RST = 2'h0;
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_BLOCKED,
        PS_START,
        PS_TRIP
    } ps_stage_e;
endpackage : ps_pkg

// File: rtl/ps_stage_core.sv
// Generic protection stage: group selection, stage state, delays, forcing.
// Assumes measurements arrive on clk; pins and buttons are synchronised here.
//
// Contract
// [RULE_01] Four independent setting groups, one active.
// [RULE_02] No active input selects default group.
// [RULE_03] Active group input selects that group.
// [RULE_04] Hold option keeps last group after loss.
// [RULE_05] Several inputs resolved by ascending/descending priority.
// [RULE_06] Global override applies without local control.
// [RULE_07] Status is idle, blocked, start or trip.
// [RULE_08] Start and trip counters, cleared on reboot.
// [RULE_09] Forcing enable allows half-second forced start/trip.
// [RULE_10] Forcing enable clears five minutes after buttons.
// [RULE_11] Forcing enable also permits output forcing.
// [RULE_12] Start on fault, trip after delay.
// [RULE_13] Fault released only below hysteresis band.
// [RULE_14] Blocked stage never trips.
// [RULE_15] Blocking freezes the running delay count.
// [RULE_16] Blocking after trip does not affect trip.
// [RULE_17] Dependent accumulation restarts below start level.
// [RULE_18] Definite timer restarts when stage deactivates.
// [RULE_19] Zero definite delay rejected unless allowed.
// [RULE_20] Release after reset delay unless latched.
// [RULE_21] Keep last eight volatile fault records.
// [RULE_22] Currents below squelch forced to zero.
// [RULE_23] Dependent delay clamped to 600 seconds.
// [RULE_24] Group and status re-evaluated every cycle.
`timescale 1ns/10ps
`default_nettype none
module ps_stage_core
    import ps_pkg::*;
#(
    parameter int MEAS_W = ps_pkg::PS_MEAS_W,
    parameter logic [ps_pkg::PS_TIME_W-1:0] FORCE_CYC = ps_pkg::PS_FORCE_CYC,
    parameter logic [ps_pkg::PS_TIME_W-1:0] TEST_TIMEOUT_CYC =
        ps_pkg::PS_TEST_TIMEOUT_CYC,
    parameter logic [ps_pkg::PS_TIME_W-1:0] DEP_MAX_CYC =
        ps_pkg::PS_DEP_MAX_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins: group control, blocking, buttons, latch release
    input wire logic digital_input_1,
    input wire logic digital_input_2,
    input wire logic digital_input_3,
    input wire logic digital_input_4,
    input wire logic block_in,
    input wire logic pushbutton_active,
    input wire logic latch_clear,
    // Group selection configuration
    input wire logic [ps_pkg::PS_GROUPS-1:0][ps_pkg::PS_GROUPS-1:0]
        group_select_input_map,
    input wire logic [ps_pkg::PS_GRP_W-1:0] default_group_when_idle,
    input wire logic group_priority_order,
    input wire logic group_keep_last,
    input wire logic global_group_override_en,
    input wire logic [ps_pkg::PS_GRP_W-1:0] global_group_override,
    // Per-group stage settings, then the global zero-delay and latch options
    input wire logic [ps_pkg::PS_GROUPS-1:0][MEAS_W-1:0] group_start_level,
    input wire logic [ps_pkg::PS_GROUPS-1:0][MEAS_W-1:0] group_hysteresis,
    input wire logic [ps_pkg::PS_GROUPS-1:0] group_dependent_mode,
    input wire logic [ps_pkg::PS_GROUPS-1:0][ps_pkg::PS_TIME_W-1:0]
        group_op_delay,
    input wire logic [ps_pkg::PS_GROUPS-1:0][ps_pkg::PS_ACC_W-1:0]
        group_dep_k,
    input wire logic [ps_pkg::PS_GROUPS-1:0][ps_pkg::PS_TIME_W-1:0]
        group_reset_delay,
    input wire logic allow_zero_delay,
    input wire logic latch_enable,
    // Measurement
    input wire logic [MEAS_W-1:0] meas_in,
    input wire logic [MEAS_W-1:0] nominal_current,
    // Test forcing
    input wire logic force_flag_set,
    input wire logic force_start_req,
    input wire logic force_trip_req,
    // Fault record read
    input wire logic [ps_pkg::PS_REC_AW-1:0] rec_rd_addr,
    output logic [ps_pkg::PS_REC_W-1:0] rec_rd_data_q,
    // Results
    output logic [ps_pkg::PS_GRP_W-1:0] active_group_q,
    output ps_pkg::ps_stage_e status_q,
    output logic start_out_q,
    output logic trip_out_q,
    output logic [31:0] start_count_q,
    output logic [31:0] trip_count_q,
    output logic force_flag_q,
    output logic setting_error_q,
    output logic [MEAS_W-1:0] meas_q
);
    localparam int NSYNC = 7;

    if (MEAS_W < 8 || MEAS_W > 32) begin : g_chk
        $error("ps_stage_core: MEAS_W must lie in 8..32");
    end

    // Two-flop synchronisers for everything that comes from a pin.
    logic [NSYNC-1:0] raw, s1_q, s2_q;
    assign raw = {latch_clear, pushbutton_active, block_in, digital_input_4,
                  digital_input_3, digital_input_2, digital_input_1};
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= raw[i];
                s2_q[i] <= s1_q[i];
            end
        end
    end
    logic [PS_GROUPS-1:0] di_s;
    logic blk_s, btn_s, lclr_s;
    assign di_s = s2_q[3:0];
    assign blk_s = s2_q[4];
    assign btn_s = s2_q[5];
    assign lclr_s = s2_q[6];

    // Per-group input activity.
    logic [PS_GROUPS-1:0] grp_act;
    logic [PS_GROUPS-1:0] map_any;
    for (genvar g = 0; g < PS_GROUPS; g++) begin : g_act
        assign grp_act[g] = |(group_select_input_map[g] & di_s); // RULE_03
        assign map_any[g] = |group_select_input_map[g];
    end

    // Group selection.
    logic [PS_GRP_W-1:0] group_d, pick_lo, pick_hi;
    logic had_ctrl_q, had_ctrl_d, any_act, local_ctrl;
    always_comb begin
        pick_lo = '0;
        pick_hi = '0;
        any_act = |grp_act;
        local_ctrl = |map_any;
        for (int g = PS_GROUPS - 1; g >= 0; g--) begin
            if (grp_act[g]) pick_lo = PS_GRP_W'(g); // RULE_05
        end
        for (int g = 0; g < PS_GROUPS; g++) begin
            if (grp_act[g]) pick_hi = PS_GRP_W'(g); // RULE_05
        end
        had_ctrl_d = had_ctrl_q;
        if (!local_ctrl && global_group_override_en) begin
            group_d = global_group_override; // RULE_06
            had_ctrl_d = 1'b0;
        end else if (any_act) begin
            group_d = group_priority_order ? pick_hi : pick_lo; // RULE_03
            had_ctrl_d = 1'b1;
        end else if (group_keep_last && had_ctrl_q) begin
            group_d = active_group_q; // RULE_04
        end else begin
            group_d = default_group_when_idle; // RULE_02
            had_ctrl_d = 1'b0;
        end
    end

    // Active group settings, taken from the group registered last cycle.
    logic [MEAS_W-1:0] thr, hyst, thr_lo;
    logic [PS_TIME_W-1:0] op_dly, rst_dly;
    logic [PS_ACC_W-1:0] dep_k;
    logic dep_mode, zero_bad;
    always_comb begin
        thr = group_start_level[active_group_q]; // RULE_01 RULE_24
        hyst = group_hysteresis[active_group_q];
        thr_lo = (thr > hyst) ? thr - hyst : '0;
        dep_mode = group_dependent_mode[active_group_q];
        dep_k = group_dep_k[active_group_q];
        rst_dly = group_reset_delay[active_group_q];
        zero_bad = !dep_mode && group_op_delay[active_group_q] == '0 &&
                   !allow_zero_delay; // RULE_19
        op_dly = zero_bad ? PS_TIME_W'(1) : group_op_delay[active_group_q];
    end

    // Squelch below 0.005 of nominal current.
    logic [MEAS_W-1:0] meas_d;
    logic [MEAS_W+10:0] sq_lhs, sq_rhs;
    always_comb begin
        sq_lhs = (MEAS_W+11)'(meas_in) * (MEAS_W+11)'(PS_SQ_DEN);
        sq_rhs = (MEAS_W+11)'(nominal_current) * (MEAS_W+11)'(PS_SQ_NUM);
        meas_d = (sq_lhs < sq_rhs) ? '0 : meas_in; // RULE_22
    end

    // Stage state.
    logic fault_q, fault_d, start_q, start_d, trip_q, trip_d;
    logic [PS_TIME_W-1:0] dt_cnt_q, dt_cnt_d, dep_t_q, dep_t_d;
    logic [PS_TIME_W-1:0] rst_cnt_q, rst_cnt_d;
    logic [PS_ACC_W-1:0] acc_q, acc_d;
    logic blocked, run, trip_hit;
    always_comb begin
        if (!fault_q) begin
            fault_d = meas_q >= thr; // RULE_12
        end else begin
            fault_d = !(meas_q < thr_lo); // RULE_13
        end
        blocked = fault_q && blk_s && !trip_q; // RULE_14 RULE_16
        run = fault_q && !blocked;
        dt_cnt_d = dt_cnt_q;
        dep_t_d = dep_t_q;
        acc_d = acc_q;
        if (!fault_q) begin
            dt_cnt_d = '0; // RULE_18
        end else if (run && dt_cnt_q < op_dly) begin
            dt_cnt_d = dt_cnt_q + PS_TIME_W'(1); // RULE_15
        end
        if (meas_q < thr) begin
            acc_d = '0; // RULE_17
            dep_t_d = '0;
        end else if (run) begin
            acc_d = acc_q + PS_ACC_W'(meas_q);
            if (dep_t_q < DEP_MAX_CYC) dep_t_d = dep_t_q + PS_TIME_W'(1);
        end
        if (dep_mode) begin
            trip_hit = run && (acc_q >= dep_k ||
                               dep_t_q >= DEP_MAX_CYC); // RULE_23
        end else begin
            trip_hit = run && dt_cnt_q >= op_dly; // RULE_12 RULE_18
        end
        start_d = start_q;
        trip_d = trip_q;
        rst_cnt_d = '0;
        if (fault_q) begin
            start_d = !blocked || trip_q;
            trip_d = trip_q || trip_hit; // RULE_16
        end else if (start_q || trip_q) begin
            if (rst_cnt_q >= rst_dly) begin
                start_d = 1'b0; // RULE_20
                trip_d = trip_q && latch_enable && !lclr_s;
            end else begin
                rst_cnt_d = rst_cnt_q + PS_TIME_W'(1);
            end
        end
    end

    // Test forcing and the visible outputs.
    logic force_flag_d, fstart_q, fstart_d, ftrip_q, ftrip_d;
    logic [PS_TIME_W-1:0] force_cnt_q, force_cnt_d, idle_cnt_q, idle_cnt_d;
    logic start_out_d, trip_out_d;
    ps_stage_e status_d;
    logic [31:0] start_count_d, trip_count_d;
    always_comb begin
        idle_cnt_d = (btn_s || force_flag_set) ? '0 : idle_cnt_q;
        if (force_flag_q && !btn_s && !force_flag_set &&
            idle_cnt_q < TEST_TIMEOUT_CYC) begin
            idle_cnt_d = idle_cnt_q + PS_TIME_W'(1);
        end
        // A set request in the cycle of the timeout keeps the flag.
        force_flag_d = force_flag_set ||
            (force_flag_q && idle_cnt_q < TEST_TIMEOUT_CYC); // RULE_10
        force_cnt_d = force_cnt_q;
        fstart_d = fstart_q;
        ftrip_d = ftrip_q;
        if (force_flag_q && (force_start_req || force_trip_req)) begin
            force_cnt_d = FORCE_CYC; // RULE_09
            ftrip_d = force_trip_req;
            fstart_d = !force_trip_req;
        end else if (force_cnt_q != '0) begin
            force_cnt_d = force_cnt_q - PS_TIME_W'(1);
        end else begin
            fstart_d = 1'b0;
            ftrip_d = 1'b0;
        end
        start_out_d = start_d || fstart_d || ftrip_d;
        trip_out_d = trip_d || ftrip_d;
        if (trip_out_d) begin
            status_d = PS_TRIP; // RULE_07
        end else if (fstart_d || (start_d && !blocked)) begin
            status_d = PS_START;
        end else if (fault_q && blocked) begin
            status_d = PS_BLOCKED;
        end else begin
            status_d = PS_IDLE;
        end
        start_count_d = start_count_q;
        trip_count_d = trip_count_q;
        if (start_out_d && !start_out_q) begin
            start_count_d = start_count_q + 32'h1; // RULE_08
        end
        if (trip_out_d && !trip_out_q) begin
            trip_count_d = trip_count_q + 32'h1; // RULE_08
        end
    end

    // Fault records: written when the stage itself trips.
    logic [PS_TS_W-1:0] ts_q;
    logic [PS_REC_AW-1:0] wr_ptr_q, wr_ptr_d;
    logic rec_wr;
    logic [PS_REC_W-1:0] rec_data;
    always_comb begin
        rec_wr = trip_d && !trip_q; // RULE_21
        wr_ptr_d = rec_wr ? wr_ptr_q + PS_REC_AW'(1) : wr_ptr_q;
        rec_data = {ts_q, PS_MEAS_W'(meas_q), dep_mode ? dep_t_q : dt_cnt_q,
                    active_group_q};
    end

    ps_fault_mem #(
        .W(PS_REC_W),
        .DEPTH(PS_REC_DEPTH),
        .AW(PS_REC_AW)
    ) u_mem (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(rec_wr),
        .wr_addr(wr_ptr_q),
        .wr_data(rec_data),
        .rd_addr(rec_rd_addr),
        .rd_data_q(rec_rd_data_q)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active_group_q <= PS_GROUP_RST;
            had_ctrl_q <= 1'b0;
            meas_q <= '0;
            fault_q <= 1'b0;
            start_q <= 1'b0;
            trip_q <= 1'b0;
            dt_cnt_q <= '0;
            dep_t_q <= '0;
            acc_q <= '0;
            rst_cnt_q <= '0;
            force_flag_q <= 1'b0;
            force_cnt_q <= '0;
            fstart_q <= 1'b0;
            ftrip_q <= 1'b0;
            idle_cnt_q <= '0;
            start_out_q <= 1'b0;
            trip_out_q <= 1'b0;
            status_q <= PS_IDLE;
            start_count_q <= 32'h0;
            trip_count_q <= 32'h0;
            setting_error_q <= 1'b0;
            ts_q <= '0;
            wr_ptr_q <= '0;
        end else begin
            active_group_q <= group_d; // RULE_24
            had_ctrl_q <= had_ctrl_d;
            meas_q <= meas_d;
            fault_q <= fault_d;
            start_q <= start_d;
            trip_q <= trip_d;
            dt_cnt_q <= dt_cnt_d;
            dep_t_q <= dep_t_d;
            acc_q <= acc_d;
            rst_cnt_q <= rst_cnt_d;
            force_flag_q <= force_flag_d; // RULE_11
            force_cnt_q <= force_cnt_d;
            fstart_q <= fstart_d;
            ftrip_q <= ftrip_d;
            idle_cnt_q <= idle_cnt_d;
            start_out_q <= start_out_d;
            trip_out_q <= trip_out_d;
            status_q <= status_d;
            start_count_q <= start_count_d;
            trip_count_q <= trip_count_d;
            setting_error_q <= zero_bad; // RULE_19
            ts_q <= ts_q + PS_TS_W'(1);
            wr_ptr_q <= wr_ptr_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_below_sq;
        sq_lhs < sq_rhs;
    endsequence
    sequence s_frozen;
        status_q == PS_BLOCKED && fault_q && blk_s ##1 blk_s && fault_q;
    endsequence

    grp_default_a: assert property ((!(!local_ctrl && global_group_override_en)
        && !any_act && !(group_keep_last && had_ctrl_q)) |=> // RULE_02
        active_group_q == $past(default_group_when_idle))
        else $error("default group not taken");
    grp_prio_a: assert property (grp_act[0] && grp_act[3] && local_ctrl // RULE_05
        && !group_priority_order |=> active_group_q == 2'h0)
        else $error("ascending priority not honoured");
    no_blk_trip_a: assert property ($rose(trip_q) |-> // RULE_14
        !$past(blocked)) else $error("trip while blocked");
    blk_freeze_a: assert property (s_frozen |-> $stable(dt_cnt_q)) // RULE_15
        else $error("delay count moved while blocked");
    trip_hold_a: assert property (trip_q && fault_q |=> trip_q) // RULE_16
        else $error("trip dropped while fault present");
    dep_restart_a: assert property (meas_q < thr |=> acc_q == '0) // RULE_17
        else $error("dependent accumulation not restarted");
    dt_restart_a: assert property (!fault_q |=> dt_cnt_q == '0) // RULE_18
        else $error("definite timer not restarted");
    cnt_trip_a: assert property ($rose(trip_out_q) |-> // RULE_08
        trip_count_q == $past(trip_count_q) + 32'h1)
        else $error("trip counter not advanced");
    squelch_a: assert property (s_below_sq |=> meas_q == '0) // RULE_22
        else $error("squelch did not zero the measurement");
    force_gate_a: assert property (!force_flag_q && force_cnt_q == '0 // RULE_09
        |=> !fstart_q && !ftrip_q) else $error("forced without enable");
endmodule : ps_stage_core
`default_nettype wire

// File: verification/ps_fe_model.sv
// Behavioural front end: measurement channel and group control pins.
// Assumes the bench sets the wanted levels on clk; they reach the pins
// one cycle later, as a sampled front end would deliver them.
`timescale 1ns/10ps
`default_nettype none
module ps_fe_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Levels wanted by the bench
    input wire logic [ps_pkg::PS_MEAS_W-1:0] meas_set,
    input wire logic [3:0] di_set,
    // Pins towards the stage
    output logic [ps_pkg::PS_MEAS_W-1:0] meas_in,
    output logic [3:0] di_pins
);
    import ps_pkg::*;
    // Inputs and samples are plain levels held between updates.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meas_in <= '0;
            di_pins <= 4'h0;
        end else begin
            meas_in <= meas_set;
            di_pins <= di_set;
        end
    end
endmodule : ps_fe_model
`default_nettype wire

// File: verification/ps_stage_core_tb.sv
// Self-checking bench for the protection stage core.
// Assumes the shortened force, test and dependent counts set below.
`timescale 1ns/10ps
`default_nettype none
module ps_stage_core_tb;
    import ps_pkg::*;
    typedef struct {int sel; logic [31:0] v;} ps_note_s;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] di_set = 4'h0;
    logic [15:0] meas_set = 16'h0000;
    logic blk = 1'b0, push = 1'b0, lclr = 1'b0, prio = 1'b0, keep = 1'b0;
    logic oven = 1'b0, zero_ok = 1'b0, latch = 1'b0;
    logic fset = 1'b0, fst = 1'b0, ftr = 1'b0;
    logic [1:0] dflt = 2'h0, ovg = 2'h0;
    logic [2:0] raddr = 3'h0;
    logic [3:0][3:0] gmap = 16'h8421;
    logic [3:0][15:0] lvl = {4{16'h0064}}, hys = {4{16'h000a}};
    logic [3:0] dep = 4'h0;
    logic [3:0][33:0] dly = {4{34'h028}}, rdly = {4{34'h004}};
    logic [3:0][47:0] kdep = {4{48'hffff_ffff_ffff}};
    logic [15:0] nom = 16'h03e8;
    logic [15:0] meas_in, mq;
    logic [3:0] dpin;
    logic [1:0] grp;
    ps_stage_e st;
    logic so, to, ff, se;
    logic [31:0] sc, tc;
    logic [83:0] rec;
    int n_fail = 0;
    int num_checks = 0;
    integer seed = 32'ha92d;
    logic [15:0] v;
    ps_note_s notes[$];
    ps_note_s n;
    event got;
    string nm[10] = '{"group", "status", "start", "trip", "starts", "trips",
                      "force", "seterr", "meas", "recgroup"};

    ps_fe_model ps_fe_model_inst (.clk(clk), .reset_n(reset_n),
        .meas_set(meas_set), .di_set(di_set), .meas_in(meas_in),
        .di_pins(dpin));

    ps_stage_core #(.FORCE_CYC(34'h014), .TEST_TIMEOUT_CYC(34'h032),
        .DEP_MAX_CYC(34'h064)) ps_stage_core_inst (
        .clk(clk), .reset_n(reset_n),
        .digital_input_1(dpin[0]), .digital_input_2(dpin[1]),
        .digital_input_3(dpin[2]), .digital_input_4(dpin[3]),
        .block_in(blk), .pushbutton_active(push), .latch_clear(lclr),
        .group_select_input_map(gmap), .default_group_when_idle(dflt),
        .group_priority_order(prio), .group_keep_last(keep),
        .global_group_override_en(oven), .global_group_override(ovg),
        .group_start_level(lvl), .group_hysteresis(hys),
        .group_dependent_mode(dep), .group_op_delay(dly),
        .group_dep_k(kdep), .group_reset_delay(rdly),
        .allow_zero_delay(zero_ok), .latch_enable(latch),
        .meas_in(meas_in), .nominal_current(nom),
        .force_flag_set(fset), .force_start_req(fst),
        .force_trip_req(ftr), .rec_rd_addr(raddr), .rec_rd_data_q(rec),
        .active_group_q(grp), .status_q(st), .start_out_q(so),
        .trip_out_q(to), .start_count_q(sc), .trip_count_q(tc),
        .force_flag_q(ff), .setting_error_q(se), .meas_q(mq));

    always #25 clk = ~clk;

    function automatic logic [31:0] obs(input int s);
        case (s)
            0: obs = 32'(grp);
            1: obs = 32'(st);
            2: obs = 32'(so);
            3: obs = 32'(to);
            4: obs = sc;
            5: obs = tc;
            6: obs = 32'(ff);
            7: obs = 32'(se);
            8: obs = 32'(mq);
            default: obs = 32'(rec[1:0]);
        endcase
    endfunction : obs

    // The watcher drains every pending note, so no expectation is lost.
    always @(got) begin
        while (notes.size() > 0) begin
            n = notes.pop_front();
            num_checks++;
            if (obs(n.sel) !== n.v) begin
                n_fail++;
                $display("ERROR %s expected %0h seen %0h", nm[n.sel], n.v,
                         obs(n.sel));
            end
        end
    end

    task chk(input int sel, input logic [31:0] ev);
        notes.push_back('{sel, ev});
        -> got;
        #1;
    endtask : chk

    task wt(input int sel, input logic [31:0] ev, input int lim);
        int i;
        i = 0;
        @(negedge clk);
        while (obs(sel) !== ev && i < lim) begin
            @(negedge clk);
            i++;
        end
        chk(sel, ev);
    endtask : wt

    task cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : cyc

    task drv(input logic [15:0] m);
        @(posedge clk);
        meas_set <= m;
    endtask : drv

    task fpulse(input logic t);
        @(posedge clk);
        ftr <= t;
        fst <= ~t;
        @(posedge clk);
        ftr <= 1'b0;
        fst <= 1'b0;
    endtask : fpulse

    task report_and_stop;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Generous bound: the sequence needs well under a thousand of the twenty thousand cycles.
    initial begin
        #1000000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        cyc(16);
        reset_n <= 1'b1;
        wt(0, 0, 1);
        chk(5, 0);
        @(posedge clk);
        dflt <= 2'h2;
        wt(0, 2, 8);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            di_set <= 4'(1 << i);
            wt(0, i, 8);
        end
        for (int o = 0; o < 2; o++) begin
            @(posedge clk);
            prio <= o[0];
            di_set <= 4'h6;
            wt(0, o ? 2 : 1, 8);
            @(posedge clk);
            di_set <= 4'hf;
            wt(0, o ? 3 : 0, 8);
        end
        @(posedge clk);
        keep <= 1'b1;
        di_set <= 4'h0;
        cyc(8);
        wt(0, 3, 0);
        @(posedge clk);
        keep <= 1'b0;
        wt(0, 2, 8);
        @(posedge clk);
        gmap <= 16'h0000;
        oven <= 1'b1;
        ovg <= 2'h1;
        wt(0, 1, 8);
        @(posedge clk);
        gmap <= 16'h8421;
        dflt <= 2'h0;
        wt(0, 0, 8);
        @(posedge clk);
        oven <= 1'b0;
        drv(16'h00c8);
        wt(2, 1, 10);
        chk(1, PS_START);
        cyc(30);
        wt(3, 0, 0);
        wt(3, 1, 20);
        chk(1, PS_TRIP);
        chk(4, 1);
        chk(5, 1);
        drv(16'h005f);
        cyc(10);
        wt(3, 1, 0);
        drv(16'h0032);
        wt(3, 0, 20);
        chk(2, 0);
        chk(1, PS_IDLE);
        // A reset count after unblocking would trip late, a free one early.
        drv(16'h00c8);
        wt(2, 1, 10);
        cyc(18);
        blk <= 1'b1;
        cyc(30);
        wt(3, 0, 0);
        chk(1, PS_BLOCKED);
        @(posedge clk);
        blk <= 1'b0;
        cyc(8);
        wt(3, 0, 0);
        wt(3, 1, 25);
        @(posedge clk);
        blk <= 1'b1;
        cyc(10);
        wt(3, 1, 0);
        @(posedge clk);
        blk <= 1'b0;
        drv(16'h0000);
        wt(3, 0, 20);
        drv(16'h00c8);
        wt(2, 1, 10);
        cyc(25);
        drv(16'h0000);
        wt(2, 0, 20);
        drv(16'h00c8);
        wt(2, 1, 10);
        cyc(30);
        wt(3, 0, 0);
        wt(3, 1, 20);
        @(posedge clk);
        latch <= 1'b1;
        drv(16'h0000);
        cyc(30);
        wt(3, 1, 0);
        @(posedge clk);
        lclr <= 1'b1;
        wt(3, 0, 20);
        @(posedge clk);
        lclr <= 1'b0;
        latch <= 1'b0;
        dep <= 4'hf;
        drv(16'h00c8);
        wt(2, 1, 10);
        cyc(60);
        drv(16'h0000);
        wt(2, 0, 20);
        drv(16'h00c8);
        wt(2, 1, 10);
        cyc(80);
        wt(3, 0, 0);
        wt(3, 1, 40);
        drv(16'h0000);
        wt(3, 0, 20);
        @(posedge clk);
        dep <= 4'h0;
        dly <= '0;
        wt(7, 1, 8);
        @(posedge clk);
        zero_ok <= 1'b1;
        wt(7, 0, 8);
        @(posedge clk);
        dly <= {4{34'h028}};
        zero_ok <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            v = 16'({$random(seed)} % 10);
            @(posedge clk);
            meas_set <= v;
            // Only the four stage trips so far have filled record slots.
            raddr <= {1'b0, 2'($random(seed))};
            repeat (3) @(negedge clk);
            chk(8, v < 16'h0005 ? 0 : v);
            chk(9, 0);
        end
        fpulse(1'b1);
        cyc(5);
        wt(3, 0, 0);
        @(posedge clk);
        fset <= 1'b1;
        push <= 1'b1;
        @(posedge clk);
        fset <= 1'b0;
        cyc(60);
        wt(6, 1, 0);
        @(posedge clk);
        push <= 1'b0;
        fpulse(1'b0);
        wt(2, 1, 5);
        fpulse(1'b1);
        wt(3, 1, 5);
        cyc(15);
        wt(3, 1, 0);
        wt(3, 0, 10);
        // Four stage trips and one forced trip.
        chk(5, 5);
        wt(6, 0, 40);
        @(posedge clk);
        reset_n <= 1'b0;
        cyc(2);
        wt(4, 0, 0);
        chk(5, 0);
        report_and_stop();
    end
endmodule : ps_stage_core_tb
`default_nettype wire
